// ===== src/scsc_ctrl.sv
// Sampling clock synthesizer control: register port, divider and filter settings,
// enables, output clock gating and the calibration sequencer.
// Assumes the analog core reports drift and calibration done as asynchronous levels.
`timescale 1ns/100ps
`include "scsc_cfg.svh"
module scsc_ctrl (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic [7:0] addr,
	input wire logic [7:0] wr_data,
	input wire logic wr_strobe,
	input wire logic rd_strobe,
	output logic [7:0] rd_data,
	input wire logic low_drift_pin,
	input wire logic high_drift_pin,
	input wire logic cal_done_pin,
	output logic [9:0] reference_divider_value,
	output logic [11:0] prescaler_value,
	output logic [3:0] output_divider_value,
	output logic [3:0] pump_current_setting,
	output logic [4:0] loop_resistor_select,
	output logic [4:0] loop_capacitor_one_select,
	output logic [4:0] loop_capacitor_two_select,
	output logic [4:0] loop_capacitor_three_select,
	output logic synth_circuit_enable,
	output logic reference_divider_enable,
	output logic synth_output_enable,
	output logic synth_bias_enable,
	output logic core_clock_enable,
	output logic core_clock_from_synth,
	output logic [2:0] output_clock_delay,
	output logic cal_start
);
	logic soft_reset;
	logic clock_source_select;
	logic cal_trigger;
	logic core_clock_bit;
	logic cal_pending;
	logic [2:0] sync_levels;
	logic cal_done_sync;
	logic cal_done_prev;
	logic cal_done_rise;
	logic timer_expired;
	logic wr_en;
	logic rd_en;
	logic trigger_toggled;
	logic soft_reset_exit;
	logic cal_take;
	logic cal_busy;
	logic [7:0] next_rd_data;
	scsc_pkg::scsc_cal_state_t cal_state;

	assign wr_en = wr_strobe && ce;
	assign rd_en = rd_strobe && ce;

	// Drift and done levels come from the analog domain
	scsc_sync2 #(
		.WIDTH(3)
	) u_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.ce(ce),
		.async_in({cal_done_pin, high_drift_pin, low_drift_pin}),
		.sync_out(sync_levels)
	);
	assign cal_done_sync = sync_levels[2];

	// Divider fields; the analog loop locks to ref * N / R
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reference_divider_value <= `SCSC_RST_REF_DIV;
			prescaler_value <= `SCSC_RST_PRESCALER;
			output_divider_value <= `SCSC_RST_OUT_DIV;
		end else if (wr_en) begin
			unique case (addr)
				`SCSC_ADDR_REF_DIV_LO: reference_divider_value[7:0] <= wr_data;
				`SCSC_ADDR_REF_DIV_HI_OUT_DIV: begin
					reference_divider_value[9:8] <= wr_data[1:0];
					output_divider_value <= wr_data[`SCSC_OUT_DIV_LSB +: 4];
				end
				`SCSC_ADDR_PRESCALER_LO: prescaler_value[7:0] <= wr_data;
				`SCSC_ADDR_PRESCALER_HI: prescaler_value[11:8] <= wr_data[3:0];
				default: begin
				end
			endcase
		end
	end

	// Pump and loop filter selections
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pump_current_setting <= `SCSC_RST_PUMP;
			loop_resistor_select <= `SCSC_RST_LOOP_SEL;
			loop_capacitor_one_select <= `SCSC_RST_LOOP_SEL;
			loop_capacitor_two_select <= `SCSC_RST_LOOP_SEL;
			loop_capacitor_three_select <= `SCSC_RST_LOOP_SEL;
		end else if (wr_en) begin
			unique case (addr)
				`SCSC_ADDR_PUMP_CURRENT: pump_current_setting <= wr_data[3:0];
				`SCSC_ADDR_LOOP_RES: loop_resistor_select <= wr_data[4:0];
				`SCSC_ADDR_LOOP_CAP1: loop_capacitor_one_select <= wr_data[4:0];
				`SCSC_ADDR_LOOP_CAP2: loop_capacitor_two_select <= wr_data[4:0];
				`SCSC_ADDR_LOOP_CAP3: loop_capacitor_three_select <= wr_data[4:0];
				default: begin
				end
			endcase
		end
	end

	// Master enables and output clock control
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			synth_circuit_enable <= 1'b0;
			reference_divider_enable <= 1'b0;
			synth_output_enable <= 1'b0;
			synth_bias_enable <= 1'b0;
			clock_source_select <= 1'b0;
			core_clock_bit <= 1'b0;
			output_clock_delay <= 3'h0;
		end else if (wr_en) begin
			unique case (addr)
				`SCSC_ADDR_ENABLES_A: begin
					synth_circuit_enable <= wr_data[`SCSC_BIT_CIRCUIT_EN];
					reference_divider_enable <= wr_data[`SCSC_BIT_REF_DIV_EN];
				end
				`SCSC_ADDR_ENABLES_B: begin
					synth_output_enable <= wr_data[`SCSC_BIT_OUTPUT_EN];
					synth_bias_enable <= wr_data[`SCSC_BIT_BIAS_EN];
				end
				`SCSC_ADDR_CLK_SOURCE: clock_source_select <= wr_data[`SCSC_BIT_CLK_SOURCE];
				`SCSC_ADDR_OUT_CLK_CTRL: begin
					core_clock_bit <= wr_data[`SCSC_BIT_CORE_CLK_EN];
					output_clock_delay <= wr_data[2:0];
				end
				default: begin
				end
			endcase
		end
	end

	// Core clock gate, held off while in soft reset, and source mux
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			core_clock_enable <= 1'b0;
			core_clock_from_synth <= 1'b0;
		end else if (ce) begin
			core_clock_enable <= core_clock_bit && !soft_reset;
			core_clock_from_synth <= clock_source_select;
		end
	end

	// Soft reset and trigger bits, with their request events
	assign trigger_toggled = wr_en && (addr == `SCSC_ADDR_CAL_TRIGGER)
		&& (wr_data[`SCSC_BIT_CAL_TRIGGER] != cal_trigger);
	assign soft_reset_exit = wr_en && (addr == `SCSC_ADDR_SOFT_RESET)
		&& soft_reset && !wr_data[`SCSC_BIT_SOFT_RESET];

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			soft_reset <= 1'b0;
			cal_trigger <= 1'b0;
		end else if (wr_en) begin
			if (addr == `SCSC_ADDR_SOFT_RESET) begin
				soft_reset <= wr_data[`SCSC_BIT_SOFT_RESET];
			end
			if (addr == `SCSC_ADDR_CAL_TRIGGER) begin
				cal_trigger <= wr_data[`SCSC_BIT_CAL_TRIGGER];
			end
		end
	end

	// A request arriving as the sequencer takes the previous one is kept
	assign cal_take = (cal_state == scsc_pkg::SCSC_CAL_IDLE) && cal_pending && !soft_reset;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cal_pending <= 1'b0;
		end else if (ce) begin
			if (trigger_toggled || soft_reset_exit) begin
				cal_pending <= 1'b1;
			end else if (cal_take) begin
				cal_pending <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cal_done_prev <= 1'b0;
		end else if (ce) begin
			cal_done_prev <= cal_done_sync;
		end
	end
	assign cal_done_rise = cal_done_sync && !cal_done_prev;

	// Watchdog ends a calibration whose done level never arrives
	scsc_cal_timer u_timer (
		.clk(clk),
		.sys_rst(sys_rst),
		.ce(ce),
		.load(cal_take),
		.abort(cal_done_rise),
		.expired(timer_expired)
	);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cal_state <= scsc_pkg::SCSC_CAL_IDLE;
			cal_start <= 1'b0;
		end else if (ce) begin
			cal_start <= 1'b0;
			unique case (cal_state)
				scsc_pkg::SCSC_CAL_IDLE: begin
					if (cal_take) begin
						cal_state <= scsc_pkg::SCSC_CAL_START;
						cal_start <= 1'b1;
					end
				end
				scsc_pkg::SCSC_CAL_START: begin
					// An early done edge also stops the watchdog, so the run must end here
					if (cal_done_rise) begin
						cal_state <= scsc_pkg::SCSC_CAL_IDLE;
					end else begin
						cal_state <= scsc_pkg::SCSC_CAL_WAIT;
					end
				end
				scsc_pkg::SCSC_CAL_WAIT: begin
					if (cal_done_rise || timer_expired) begin
						cal_state <= scsc_pkg::SCSC_CAL_IDLE;
					end
				end
				default: cal_state <= scsc_pkg::SCSC_CAL_IDLE;
			endcase
		end
	end

	assign cal_busy = cal_pending || (cal_state != scsc_pkg::SCSC_CAL_IDLE);

	// Read mux; data stand only in the cycle after the strobe
	always_comb begin
		next_rd_data = 8'h00;
		unique case (addr)
			`SCSC_ADDR_SOFT_RESET: next_rd_data[`SCSC_BIT_SOFT_RESET] = soft_reset;
			`SCSC_ADDR_CLK_SOURCE: next_rd_data[`SCSC_BIT_CLK_SOURCE] = clock_source_select;
			`SCSC_ADDR_REF_DIV_LO: next_rd_data = reference_divider_value[7:0];
			`SCSC_ADDR_REF_DIV_HI_OUT_DIV:
				next_rd_data = {output_divider_value, 2'b00, reference_divider_value[9:8]};
			`SCSC_ADDR_PRESCALER_LO: next_rd_data = prescaler_value[7:0];
			`SCSC_ADDR_PRESCALER_HI: next_rd_data = {4'h0, prescaler_value[11:8]};
			`SCSC_ADDR_PUMP_CURRENT: next_rd_data = {4'h0, pump_current_setting};
			`SCSC_ADDR_ENABLES_A:
				next_rd_data = {6'h00, reference_divider_enable, synth_circuit_enable};
			`SCSC_ADDR_LOOP_RES: next_rd_data = {3'h0, loop_resistor_select};
			`SCSC_ADDR_LOOP_CAP3: next_rd_data = {3'h0, loop_capacitor_three_select};
			`SCSC_ADDR_LOOP_CAP1: next_rd_data = {3'h0, loop_capacitor_one_select};
			`SCSC_ADDR_LOOP_CAP2: next_rd_data = {3'h0, loop_capacitor_two_select};
			`SCSC_ADDR_ENABLES_B: next_rd_data = {6'h00, synth_bias_enable, synth_output_enable};
			`SCSC_ADDR_CAL_TRIGGER: next_rd_data[`SCSC_BIT_CAL_TRIGGER] = cal_trigger;
			`SCSC_ADDR_OUT_CLK_CTRL:
				next_rd_data = {4'h0, core_clock_bit, output_clock_delay};
			`SCSC_ADDR_STATUS: begin
				next_rd_data[`SCSC_BIT_CAL_BUSY] = cal_busy;
				next_rd_data[`SCSC_BIT_LOW_DRIFT] = sync_levels[0];
				next_rd_data[`SCSC_BIT_HIGH_DRIFT] = sync_levels[1];
			end
			default: next_rd_data = 8'h00;
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rd_data <= 8'h00;
		end else if (ce) begin
			rd_data <= rd_strobe ? next_rd_data : 8'h00;
		end
	end

	// Checks; a frozen clock enable stretches every sequence, so antecedents need ce
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	ref_div_low_a: assert property (wr_en && addr == `SCSC_ADDR_REF_DIV_LO
		|=> reference_divider_value[7:0] == $past(wr_data))
		else $error("reference divider low byte not stored");

	presc_high_a: assert property (wr_en && addr == `SCSC_ADDR_PRESCALER_HI
		|=> prescaler_value[11:8] == $past(wr_data[3:0]))
		else $error("prescaler high nibble not stored");

	shared_reg_a: assert property (wr_en && addr == `SCSC_ADDR_REF_DIV_HI_OUT_DIV
		|=> output_divider_value == $past(wr_data[7:4])
		&& reference_divider_value[9:8] == $past(wr_data[1:0]))
		else $error("shared divider register split wrong");

	toggle_request_a: assert property (trigger_toggled
		|=> cal_pending || cal_state != scsc_pkg::SCSC_CAL_IDLE)
		else $error("trigger toggle lost");

	soft_exit_cal_a: assert property (soft_reset_exit
		&& cal_state == scsc_pkg::SCSC_CAL_IDLE ##1 ce |=> cal_start)
		else $error("soft reset exit did not start calibration");

	status_busy_a: assert property (rd_en && addr == `SCSC_ADDR_STATUS
		|=> rd_data[`SCSC_BIT_CAL_BUSY] == $past(cal_busy))
		else $error("calibration status misreported");

	drift_read_a: assert property (rd_en && addr == `SCSC_ADDR_STATUS
		|=> rd_data[2:1] == $past(sync_levels[1:0]))
		else $error("drift flags misreported");

	core_gate_a: assert property (core_clock_enable && $past(ce)
		|-> $past(core_clock_bit) && !$past(soft_reset))
		else $error("core clock passed while gated");

	read_once_a: assert property (!$past(rd_strobe) && $past(ce) |-> rd_data == 8'h00)
		else $error("read data stood beyond one cycle");

	pulse_once_a: assert property (cal_start && ce |=> !cal_start)
		else $error("calibration start pulse stretched");

	source_follow_a: assert property ($past(ce)
		|-> core_clock_from_synth == $past(clock_source_select))
		else $error("core clock source not following select");

	pump_store_a: assert property (wr_en && addr == `SCSC_ADDR_PUMP_CURRENT
		|=> pump_current_setting == $past(wr_data[3:0]))
		else $error("pump current not stored");

	loop_res_a: assert property (wr_en && addr == `SCSC_ADDR_LOOP_RES
		|=> loop_resistor_select == $past(wr_data[4:0]))
		else $error("loop resistor select not stored");

	bias_store_a: assert property (wr_en && addr == `SCSC_ADDR_ENABLES_B
		|=> synth_bias_enable == $past(wr_data[`SCSC_BIT_BIAS_EN]))
		else $error("bias enable not stored");

	delay_store_a: assert property (wr_en && addr == `SCSC_ADDR_OUT_CLK_CTRL
		|=> output_clock_delay == $past(wr_data[2:0]))
		else $error("output clock delay not stored");

	watchdog_end_a: assert property (cal_state == scsc_pkg::SCSC_CAL_WAIT
		&& timer_expired && ce |=> cal_state == scsc_pkg::SCSC_CAL_IDLE)
		else $error("watchdog expiry did not end calibration");

	cover_trigger_c: cover property (trigger_toggled ##[1:3] cal_start);
	cover_soft_exit_c: cover property (soft_reset_exit ##[1:3] cal_start);
	cover_done_c: cover property (cal_state == scsc_pkg::SCSC_CAL_WAIT && cal_done_rise);
	cover_timeout_c: cover property (cal_state == scsc_pkg::SCSC_CAL_WAIT && timer_expired);
endmodule

// ===== src/scsc_cfg.svh
// Register map, field positions, reset values and timing counts of the sampling clock
// synthesizer control block. Assumes an 8-bit register port and a 10 MHz system clock.
`ifndef SCSC_CFG_SVH
`define SCSC_CFG_SVH

`define SCSC_ADDR_SOFT_RESET 8'h00
`define SCSC_ADDR_CLK_SOURCE 8'h53
`define SCSC_ADDR_REF_DIV_LO 8'h54
`define SCSC_ADDR_REF_DIV_HI_OUT_DIV 8'h55
`define SCSC_ADDR_PRESCALER_LO 8'h56
`define SCSC_ADDR_PRESCALER_HI 8'h57
`define SCSC_ADDR_PUMP_CURRENT 8'h58
`define SCSC_ADDR_ENABLES_A 8'h59
`define SCSC_ADDR_LOOP_RES 8'h5A
`define SCSC_ADDR_LOOP_CAP3 8'h5B
`define SCSC_ADDR_LOOP_CAP1 8'h5C
`define SCSC_ADDR_LOOP_CAP2 8'h5D
`define SCSC_ADDR_ENABLES_B 8'h5F
`define SCSC_ADDR_CAL_TRIGGER 8'h6B
`define SCSC_ADDR_OUT_CLK_CTRL 8'h6D
`define SCSC_ADDR_STATUS 8'hD1

`define SCSC_BIT_SOFT_RESET 0
`define SCSC_BIT_CLK_SOURCE 0
`define SCSC_BIT_CIRCUIT_EN 0
`define SCSC_BIT_REF_DIV_EN 1
`define SCSC_BIT_OUTPUT_EN 0
`define SCSC_BIT_BIAS_EN 1
`define SCSC_BIT_CAL_TRIGGER 0
`define SCSC_BIT_CORE_CLK_EN 3
`define SCSC_BIT_CAL_BUSY 0
`define SCSC_BIT_LOW_DRIFT 1
`define SCSC_BIT_HIGH_DRIFT 2
`define SCSC_OUT_DIV_LSB 4

`define SCSC_RST_REF_DIV 10'h001
`define SCSC_RST_PRESCALER 12'h001
`define SCSC_RST_OUT_DIV 4'h1
`define SCSC_RST_PUMP 4'h4
`define SCSC_RST_LOOP_SEL 5'h1F

`define SCSC_CLK_PERIOD_NS 100
`define SCSC_CAL_TIME_NS 100000
`define SCSC_CAL_CYCLES (`SCSC_CAL_TIME_NS / `SCSC_CLK_PERIOD_NS)
`define SCSC_CAL_CNT_W 10

`endif

// ===== src/scsc_pkg.sv
// Types shared by the sampling clock synthesizer control block.
// Assumes scsc_cfg.svh supplies all numeric constants.
package scsc_pkg;
	typedef enum logic [1:0] {
		SCSC_CAL_IDLE,
		SCSC_CAL_START,
		SCSC_CAL_WAIT
	} scsc_cal_state_t;
endpackage

// ===== src/scsc_sync2.sv
// Two-flop synchronizer for levels arriving from the analog core.
// Assumes the inputs are slow levels; pulses shorter than a cycle may be lost.
`timescale 1ns/100ps
module scsc_sync2 #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			meta <= '0;
			sync_out <= '0;
		end else if (ce) begin
			meta <= async_in;
			sync_out <= meta;
		end
	end
endmodule

// ===== src/scsc_cal_timer.sv
// Calibration watchdog: a load starts a countdown, expiry is a one-cycle pulse.
// Assumes a single clock; frozen while ce is low.
`timescale 1ns/100ps
`include "scsc_cfg.svh"
module scsc_cal_timer (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic load,
	input wire logic abort,
	output logic expired
);
	localparam logic [`SCSC_CAL_CNT_W-1:0] CAL_LAST = `SCSC_CAL_CNT_W'(`SCSC_CAL_CYCLES - 1);
	logic [`SCSC_CAL_CNT_W-1:0] count;
	logic running;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			count <= '0;
			running <= 1'b0;
			expired <= 1'b0;
		end else if (ce) begin
			expired <= 1'b0;
			if (load) begin
				count <= CAL_LAST;
				running <= 1'b1;
			end else if (abort) begin
				running <= 1'b0;
			end else if (running) begin
				if (count == '0) begin
					running <= 1'b0;
					expired <= 1'b1;
				end else begin
					count <= count - 1'b1;
				end
			end
		end
	end
endmodule

// ===== testbench/scsc_ctrl_tb.sv
// Self-checking bench for the sampling clock synthesizer control block.
// Assumes scsc_cfg.svh on the include path and a 10 MHz clock; analog pins driven here.
`timescale 1ns/100ps
`include "scsc_cfg.svh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_count++; \
	$display("BAD t=%0t got %h exp %h", $time, (a), (e)); end end
module sampling_clock_synth_control_tb_top;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic ce = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [7:0] wr_data = 8'h00;
	logic wr_strobe = 1'b0;
	logic rd_strobe = 1'b0;
	logic [7:0] rd_data;
	logic low_drift_pin = 1'b0;
	logic high_drift_pin = 1'b0;
	logic cal_done_pin = 1'b0;
	logic [9:0] reference_divider_value;
	logic [11:0] prescaler_value;
	logic [3:0] output_divider_value;
	logic [3:0] pump_current_setting;
	logic [4:0] loop_resistor_select;
	logic [4:0] loop_capacitor_one_select;
	logic [4:0] loop_capacitor_two_select;
	logic [4:0] loop_capacitor_three_select;
	logic synth_circuit_enable;
	logic reference_divider_enable;
	logic synth_output_enable;
	logic synth_bias_enable;
	logic core_clock_enable;
	logic core_clock_from_synth;
	logic [2:0] output_clock_delay;
	logic cal_start;
	int err_count = 0;
	int checks = 0;
	int starts = 0;
	logic [7:0] d;

	always #50 clk = ~clk;

	// Counting pulses lets the calibration tasks judge merges without exact alignment
	always @(posedge clk) begin
		if (cal_start === 1'b1)
			starts++;
	end

	scsc_ctrl u_dut (
		.clk(clk), .sys_rst(sys_rst), .ce(ce), .addr(addr), .wr_data(wr_data),
		.wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data),
		.low_drift_pin(low_drift_pin), .high_drift_pin(high_drift_pin),
		.cal_done_pin(cal_done_pin), .reference_divider_value(reference_divider_value),
		.prescaler_value(prescaler_value), .output_divider_value(output_divider_value),
		.pump_current_setting(pump_current_setting), .loop_resistor_select(loop_resistor_select),
		.loop_capacitor_one_select(loop_capacitor_one_select),
		.loop_capacitor_two_select(loop_capacitor_two_select),
		.loop_capacitor_three_select(loop_capacitor_three_select),
		.synth_circuit_enable(synth_circuit_enable),
		.reference_divider_enable(reference_divider_enable),
		.synth_output_enable(synth_output_enable), .synth_bias_enable(synth_bias_enable),
		.core_clock_enable(core_clock_enable), .core_clock_from_synth(core_clock_from_synth),
		.output_clock_delay(output_clock_delay), .cal_start(cal_start)
	);

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wr_data <= v;
		wr_strobe <= 1'b1;
		@(posedge clk);
		wr_strobe <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so sample just past that edge
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		addr <= a;
		rd_strobe <= 1'b1;
		@(posedge clk);
		rd_strobe <= 1'b0;
		#1;
		v = rd_data;
	endtask

	task automatic finish_cal();
		int n;
		@(posedge clk);
		cal_done_pin <= 1'b1;
		n = 0;
		d = 8'hFF;
		while (d[0] !== 1'b0 && n < 20) begin
			rd(`SCSC_ADDR_STATUS, d);
			n++;
		end
		`CHK(d, 8'h00)
		@(posedge clk);
		cal_done_pin <= 1'b0;
		repeat (3) @(posedge clk);
	endtask

	task automatic t_reset_values();
		#1;
		`CHK({reference_divider_value, prescaler_value, output_divider_value}, 26'h0010011)
		`CHK({pump_current_setting, loop_resistor_select}, 9'h09F)
		`CHK({loop_capacitor_one_select, loop_capacitor_two_select}, 10'h3FF)
		`CHK(loop_capacitor_three_select, 5'h1F)
		`CHK({synth_circuit_enable, reference_divider_enable}, 2'h0)
		`CHK({synth_output_enable, synth_bias_enable}, 2'h0)
		`CHK({core_clock_enable, core_clock_from_synth, output_clock_delay}, 5'h00)
		`CHK({rd_data, cal_start}, 9'h000)
	endtask

	task automatic t_dividers();
		wr(`SCSC_ADDR_REF_DIV_LO, 8'hFF);
		wr(`SCSC_ADDR_REF_DIV_HI_OUT_DIV, 8'h63);
		wr(`SCSC_ADDR_PRESCALER_LO, 8'hFF);
		wr(`SCSC_ADDR_PRESCALER_HI, 8'h0F);
		#1;
		`CHK(reference_divider_value, 10'h3FF)
		`CHK(prescaler_value, 12'hFFF)
		`CHK(output_divider_value, 4'h6)
		rd(`SCSC_ADDR_REF_DIV_HI_OUT_DIV, d);
		`CHK(d, 8'h63)
		rd(`SCSC_ADDR_PRESCALER_HI, d);
		`CHK(d, 8'h0F)
		#100;
		`CHK(rd_data, 8'h00)
		// A 100 MHz reference gives 10 MHz compare, 1.2 GHz oscillator, 240 MHz out
		wr(`SCSC_ADDR_REF_DIV_HI_OUT_DIV, 8'h50);
		wr(`SCSC_ADDR_PRESCALER_LO, 8'h78);
		wr(`SCSC_ADDR_PRESCALER_HI, 8'h00);
		wr(`SCSC_ADDR_REF_DIV_LO, 8'h0A);
		#1;
		`CHK({reference_divider_value, prescaler_value}, 22'h00A078)
		`CHK(output_divider_value, 4'h5)
	endtask

	task automatic t_filter();
		wr(`SCSC_ADDR_PUMP_CURRENT, 8'h0F);
		wr(`SCSC_ADDR_LOOP_RES, 8'h07);
		wr(`SCSC_ADDR_LOOP_CAP3, 8'h02);
		wr(`SCSC_ADDR_LOOP_CAP1, 8'h01);
		wr(`SCSC_ADDR_LOOP_CAP2, 8'h10);
		#1;
		`CHK(pump_current_setting, 4'hF)
		`CHK({loop_resistor_select, loop_capacitor_three_select}, 10'h0E2)
		`CHK({loop_capacitor_one_select, loop_capacitor_two_select}, 10'h030)
		// Stalled clock enable must drop a write
		@(posedge clk);
		ce <= 1'b0;
		wr(`SCSC_ADDR_PUMP_CURRENT, 8'h01);
		ce <= 1'b1;
		#1;
		`CHK(pump_current_setting, 4'hF)
		wr(8'h60, 8'hFF);
		rd(8'h60, d);
		`CHK(d, 8'h00)
		// Recommended codes for a 10 MHz comparison frequency
		wr(`SCSC_ADDR_PUMP_CURRENT, 8'h04);
		wr(`SCSC_ADDR_LOOP_RES, 8'h1F);
		wr(`SCSC_ADDR_LOOP_CAP3, 8'h02);
		wr(`SCSC_ADDR_LOOP_CAP1, 8'h01);
		wr(`SCSC_ADDR_LOOP_CAP2, 8'h01);
		#1;
		`CHK({pump_current_setting, loop_resistor_select}, 9'h09F)
		`CHK(loop_capacitor_three_select, 5'h02)
		`CHK({loop_capacitor_one_select, loop_capacitor_two_select}, 10'h021)
	endtask

	task automatic t_enables();
		wr(`SCSC_ADDR_ENABLES_A, 8'h01);
		wr(`SCSC_ADDR_ENABLES_B, 8'h02);
		wr(`SCSC_ADDR_OUT_CLK_CTRL, 8'h0D);
		wr(`SCSC_ADDR_CLK_SOURCE, 8'h01);
		@(posedge clk);
		#1;
		`CHK({synth_circuit_enable, reference_divider_enable}, 2'h2)
		`CHK({synth_output_enable, synth_bias_enable}, 2'h1)
		`CHK(core_clock_enable, 1'b1)
		`CHK(output_clock_delay, 3'h5)
		`CHK(core_clock_from_synth, 1'b1)
		wr(`SCSC_ADDR_OUT_CLK_CTRL, 8'h07);
		wr(`SCSC_ADDR_CLK_SOURCE, 8'h00);
		@(posedge clk);
		#1;
		`CHK({core_clock_enable, core_clock_from_synth, output_clock_delay}, 5'h07)
	endtask

	task automatic t_calibration();
		int s0;
		wr(`SCSC_ADDR_CAL_TRIGGER, 8'h01);
		#1;
		`CHK(cal_start, 1'b0)
		@(posedge clk);
		#1;
		`CHK(cal_start, 1'b1)
		@(posedge clk);
		#1;
		`CHK(cal_start, 1'b0)
		rd(`SCSC_ADDR_STATUS, d);
		`CHK(d, 8'h01)
		finish_cal();
		// Same trigger value again is not a toggle
		s0 = starts;
		wr(`SCSC_ADDR_CAL_TRIGGER, 8'h01);
		repeat (5) @(posedge clk);
		`CHK(starts - s0, 0)
		// Soft reset holds off a toggle; exit merges both into one run
		wr(`SCSC_ADDR_OUT_CLK_CTRL, 8'h08);
		wr(`SCSC_ADDR_SOFT_RESET, 8'h01);
		wr(`SCSC_ADDR_CAL_TRIGGER, 8'h00);
		repeat (5) @(posedge clk);
		#1;
		`CHK(starts - s0, 0)
		`CHK(core_clock_enable, 1'b0)
		wr(`SCSC_ADDR_SOFT_RESET, 8'h00);
		repeat (5) @(posedge clk);
		#1;
		`CHK(starts - s0, 1)
		`CHK(core_clock_enable, 1'b1)
		finish_cal();
	endtask

	task automatic t_drift();
		low_drift_pin <= 1'b1;
		repeat (4) @(posedge clk);
		rd(`SCSC_ADDR_STATUS, d);
		`CHK(d, 8'h02)
		@(posedge clk);
		high_drift_pin <= 1'b1;
		low_drift_pin <= 1'b0;
		repeat (4) @(posedge clk);
		wr(`SCSC_ADDR_STATUS, 8'hFF);
		rd(`SCSC_ADDR_STATUS, d);
		`CHK(d, 8'h04)
		@(posedge clk);
		high_drift_pin <= 1'b0;
	endtask

	// Done never arrives, so only the watchdog can end this run
	task automatic t_timeout();
		wr(`SCSC_ADDR_CAL_TRIGGER, 8'h01);
		repeat (`SCSC_CAL_CYCLES - 10) @(posedge clk);
		rd(`SCSC_ADDR_STATUS, d);
		`CHK(d, 8'h01)
		repeat (12) @(posedge clk);
		rd(`SCSC_ADDR_STATUS, d);
		`CHK(d, 8'h00)
	endtask

	task automatic wrap_up();
		$display("checks=%0d err_count=%0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Hang guard well above the longest scenario
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		wrap_up();
	end

	initial begin
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		t_reset_values();
		t_dividers();
		t_filter();
		t_enables();
		t_calibration();
		t_drift();
		t_timeout();
		repeat (3) @(posedge clk);
		wrap_up();
	end
endmodule
